//--- verilog/irq_priority_pending_ctrl.sv
// interrupt pending/active tracking with per-line priority
// assumes an APB master on pclk, peripherals on irq_in and a
// core that strobes entry and return with the line number
`timescale 1ns/10ps

// Function
// - keep a two-bit priority for every interrupt in eight priority words.
// - interrupt M lives in word M/4, byte lane M mod 4.
// - priority values 0 to 3, smaller value wins.
// - only bits 7:6 of a lane stored; low six read zero.
// - pulse inputs sampled on each rising clock edge with ce high and latched pending.
// - pending on level while not active, rising edge, or set-pending write.
// - entry to service clears pending and marks active.
// - level return: pending again if input high, else inactive.
// - pulse during service gives pending and active; stays pending after return.
// - no pulse during service: return leaves the line inactive.
// - level clear-pending is ignored while the input is still high.
// - pulse clear-pending: pending to inactive, active-pending to active.
// - a disabled interrupt can still become pending.
// - only pending and enabled lines are presented, by priority.
// - clear-pending never changes the active state.
module irq_priority_pending_ctrl
	import irq_pkg::*;
#(
	parameter int N     = N_IRQ,
	parameter int IDX_W = $clog2(N_IRQ)
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [N-1:0]      irq_in,
	input  wire logic              svc_enter,
	input  wire logic [IDX_W-1:0]  svc_enter_num,
	input  wire logic              svc_leave,
	input  wire logic [IDX_W-1:0]  svc_leave_num,
	output logic                   irq_req,
	output logic [IDX_W-1:0]       irq_num,
	output logic [PRIO_W-1:0]      irq_prio
);
	// ************************************************************
	// declarations
	// ************************************************************
	logic [N-1:0]        en_r;
	logic [N-1:0]        type_r;
	logic [PRIO_W-1:0]   prio_r [N];
	logic [N-1:0]        pend, act, cand;
	logic [N*PRIO_W-1:0] prio_flat;
	logic [N*LANE_W-1:0] prio_bytes;
	logic [31:0]         prdata_r, rd_word;
	logic                pslverr_r, rd_err;
	logic                irq_req_r;
	logic [IDX_W-1:0]    irq_num_r;
	logic [PRIO_W-1:0]   irq_prio_r;
	logic                sel_valid;
	logic [IDX_W-1:0]    sel_num;
	logic [PRIO_W-1:0]   sel_prio;
	apb_phase_t          phase;
	logic                setup, wr_take;
	logic                rd_cap_r;
	logic [N-1:0]        beats_win, ties_low;
	logic                hit_set_en, hit_clr_en, hit_set_pend, hit_clr_pend;
	logic                hit_active, hit_type, hit_prio;
	logic [2:0]          prio_idx;

	// ************************************************************
	// apb decode
	// ************************************************************
	// zero wait states while ce is high, except one when ce froze the setup edge of a
	// read: prdata must be loaded before the access may end
	assign pready   = ce & (pwrite | ~penable | rd_cap_r);
	assign setup    = psel & ~penable;
	assign wr_take  = ce & psel & penable & pwrite;
	assign phase    = !psel ? PH_IDLE : (penable ? PH_ACCESS : PH_SETUP);

	// word decode; bits 1:0 ignored except above 0x41C in the priority range, aligned use is assumed
	assign hit_set_en   = paddr[ADDR_W-1:2] == OFS_SET_EN[ADDR_W-1:2];
	assign hit_clr_en   = paddr[ADDR_W-1:2] == OFS_CLR_EN[ADDR_W-1:2];
	assign hit_set_pend = paddr[ADDR_W-1:2] == OFS_SET_PEND[ADDR_W-1:2];
	assign hit_clr_pend = paddr[ADDR_W-1:2] == OFS_CLR_PEND[ADDR_W-1:2];
	assign hit_active   = paddr[ADDR_W-1:2] == OFS_ACTIVE[ADDR_W-1:2];
	assign hit_type     = paddr[ADDR_W-1:2] == OFS_TYPE[ADDR_W-1:2];
	assign hit_prio     = paddr >= OFS_PRIO_BASE && paddr <= OFS_PRIO_LAST;
	assign prio_idx     = paddr[4:2];
	assign rd_err       = ~(hit_set_en | hit_clr_en | hit_set_pend | hit_clr_pend |
		hit_active | hit_type | hit_prio);

	// ************************************************************
	// read mux
	// ************************************************************
	// both set and clear views read back the same state
	assign rd_word = (hit_set_en | hit_clr_en)     ? en_r :
		(hit_set_pend | hit_clr_pend) ? pend :
		hit_active                    ? act :
		hit_type                      ? type_r :
		hit_prio                      ? prio_bytes[{prio_idx, 5'h00} +: 32] :
		RST_WORD;

	// read data caught in the setup cycle so prdata is a flop;
	// a state change during the access phase shows on the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= RST_WORD;
			pslverr_r <= 1'b0;
			rd_cap_r  <= 1'b0;
		end else if (ce) begin
			// set once loaded, dropped when the access ends
			rd_cap_r <= psel & ~(penable & pready);
			if (phase != PH_IDLE && !rd_cap_r) begin
				prdata_r  <= pwrite ? RST_WORD : rd_word;
				pslverr_r <= rd_err;
			end
		end
	end

	assign prdata  = prdata_r;
	assign pslverr = pslverr_r & psel & penable & pready;

	// ************************************************************
	// enable and type words
	// ************************************************************
	// type bit high selects pulse detection for that line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_r   <= RST_WORD[N-1:0];
			type_r <= RST_WORD[N-1:0];
		end else if (wr_take) begin
			if (hit_set_en)
				en_r <= en_r | pwdata[N-1:0];
			else if (hit_clr_en)
				en_r <= en_r & ~pwdata[N-1:0];
			if (hit_type)
				type_r <= pwdata[N-1:0];
		end
	end

	// ************************************************************
	// per-line priority and state
	// ************************************************************
	for (genvar i = 0; i < N; i++) begin : g_line
		logic prio_we;
		logic set_pend_w, clr_pend_w, enter_i, leave_i;

		// field lives in word i/4, lane i%4, bits [7:6] of that lane
		assign prio_we = wr_take & hit_prio & (prio_idx == 3'(i / LANES));

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn)
				prio_r[i] <= RST_PRIO;
			else if (prio_we)
				prio_r[i] <= pwdata[(i % LANES) * LANE_W + PRIO_LSB +: PRIO_W];
		end

		// low six bits of each lane are constant zero
		assign prio_bytes[i*LANE_W +: LANE_W] = {prio_r[i], {PRIO_LSB{1'b0}}};
		assign prio_flat[i*PRIO_W +: PRIO_W]  = prio_r[i];

		// candidates that should have beaten the chosen line, for checks
		assign beats_win[i] = cand[i] & (prio_r[i] < sel_prio);
		assign ties_low[i]  = cand[i] & (prio_r[i] == sel_prio) & (IDX_W'(i) < sel_num);

		// set-pending ignores the enable bit
		assign set_pend_w = wr_take & hit_set_pend & pwdata[i];
		assign clr_pend_w = wr_take & hit_clr_pend & pwdata[i];
		assign enter_i    = svc_enter & (svc_enter_num == IDX_W'(i));
		assign leave_i    = svc_leave & (svc_leave_num == IDX_W'(i));

		irq_line_state u_state (
			.pclk     (pclk),
			.presetn  (presetn),
			.ce       (ce),
			.irq_in   (irq_in[i]),
			.is_pulse (type_r[i]),
			.set_pend (set_pend_w),
			.clr_pend (clr_pend_w),
			.enter    (enter_i),
			.leave    (leave_i),
			.pend     (pend[i]),
			.act      (act[i])
		);
	end

	// ************************************************************
	// presentation to the core
	// ************************************************************
	// an active line is not offered again until it returns
	assign cand = pend & en_r & ~act;

	irq_select #(
		.N     (N),
		.W     (PRIO_W),
		.IDX_W (IDX_W)
	) u_select (
		.cand      (cand),
		.prio_flat (prio_flat),
		.valid     (sel_valid),
		.num       (sel_num),
		.prio      (sel_prio)
	);

	// one cycle of latency buys a clean flop-driven request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req_r  <= 1'b0;
			irq_num_r  <= '0;
			irq_prio_r <= RST_PRIO;
		end else if (ce) begin
			irq_req_r  <= sel_valid;
			irq_num_r  <= sel_num;
			irq_prio_r <= sel_prio;
		end
	end

	assign irq_req  = irq_req_r;
	assign irq_num  = irq_num_r;
	assign irq_prio = irq_prio_r;

	// ************************************************************
	// checks
	// ************************************************************
	property p_prio_low_zero;
		@(posedge pclk) disable iff (!presetn)
		ce && setup && !pwrite && hit_prio |=> prdata[PRIO_LSB-1:0] == 6'h00;
	endproperty
	a_prio_low_zero: assert property (p_prio_low_zero) else $error("low bits not zero");

	sequence s_base_write;
		ce && psel && penable && pwrite && paddr == OFS_PRIO_BASE;
	endsequence

	sequence s_base_read;
		ce && setup && !pwrite && paddr == OFS_PRIO_BASE;
	endsequence

	// write, one idle cycle, then the read setup of the same word
	property p_prio_readback;
		@(posedge pclk) disable iff (!presetn)
		s_base_write ##1 !psel ##1 s_base_read
			|=> prdata[31:24] == {$past(pwdata[31:30], 3), 6'h00};
	endproperty
	a_prio_readback: assert property (p_prio_readback) else $error("lane 3 readback");

	property p_disabled_pend;
		@(posedge pclk) disable iff (!presetn)
		wr_take && hit_set_pend && pwdata[0] && !en_r[0]
			|=> pend[0] ##1 !(irq_req && irq_num == '0);
	endproperty
	a_disabled_pend: assert property (p_disabled_pend) else $error("disabled line wrong");

	property p_no_cand_no_req;
		@(posedge pclk) disable iff (!presetn)
		ce && cand == '0 |=> !irq_req;
	endproperty
	a_no_cand_no_req: assert property (p_no_cand_no_req) else $error("spurious request");

	// no candidate of equal value and lower number was passed over
	property p_tie_low;
		@(posedge pclk) disable iff (!presetn)
		ce && sel_valid |-> ties_low == '0;
	endproperty
	a_tie_low: assert property (p_tie_low) else $error("tie not to low number");

	// no candidate with a smaller value was passed over
	property p_prio_order;
		@(posedge pclk) disable iff (!presetn)
		ce && sel_valid |-> beats_win == '0;
	endproperty
	a_prio_order: assert property (p_prio_order) else $error("higher value won");

	property p_reset_state;
		@(posedge pclk)
		$rose(presetn) |-> en_r == '0 && pend == '0 && act == '0 && !irq_req && prdata == '0;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state not zero");

endmodule : irq_priority_pending_ctrl

//--- verilog/irq_pkg.sv
// shared constants of the interrupt priority/pending controller
// assumes a 32-bit APB slave port and one processor clock
package irq_pkg;

	// ************************************************************
	// sizes
	// ************************************************************
	localparam int N_IRQ    = 32;  // number of interrupt lines
	localparam int PRIO_W   = 2;   // stored priority bits per line
	localparam int PRIO_LSB = 6;   // stored bits sit at [7:6] of a lane
	localparam int LANE_W   = 8;   // one priority field per byte lane
	localparam int LANES    = 4;   // fields per priority word
	localparam int ADDR_W   = 12;  // decoded APB address bits

	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [ADDR_W-1:0] OFS_SET_EN    = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_CLR_EN    = 12'h180;
	localparam logic [ADDR_W-1:0] OFS_SET_PEND  = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_CLR_PEND  = 12'h280;
	localparam logic [ADDR_W-1:0] OFS_ACTIVE    = 12'h300;
	localparam logic [ADDR_W-1:0] OFS_TYPE      = 12'h380;
	localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 12'h400;
	localparam logic [ADDR_W-1:0] OFS_PRIO_LAST = 12'h41C;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [31:0]       RST_WORD = 32'h00000000;
	localparam logic [PRIO_W-1:0] RST_PRIO = 2'h0;

	// apb phase seen by the slave, one-hot
	typedef enum logic [2:0] {
		PH_IDLE   = 3'b001,
		PH_SETUP  = 3'b010,
		PH_ACCESS = 3'b100
	} apb_phase_t;

endpackage : irq_pkg

//--- verilog/irq_line_state.sv
// pending/active state of one interrupt line
// assumes irq_in synchronous to pclk and strobes of one cycle
`timescale 1ns/10ps
module irq_line_state
	import irq_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic ce,
	input  wire logic irq_in,
	input  wire logic is_pulse,
	input  wire logic set_pend,
	input  wire logic clr_pend,
	input  wire logic enter,
	input  wire logic leave,
	output logic      pend,
	output logic      act
);
	logic pend_r, pend_nxt;
	logic act_r, act_nxt;
	logic prev_r;
	logic rise, lvl_set, hw_set, clr_ok;

	// ************************************************************
	// next state
	// ************************************************************
	// edge seen on the clock, so a pulse must last one full cycle
	assign rise     = irq_in & ~prev_r;
	// level repends only while not active, or right at return
	assign lvl_set  = ~is_pulse & irq_in & ((~act_r & ~enter) | leave);
	assign hw_set   = set_pend | lvl_set | (is_pulse & rise);
	// a held level swallows the clear, a pulse never does
	assign clr_ok   = clr_pend & ~(~is_pulse & irq_in);
	// sets win over entry and clear in the same cycle
	assign pend_nxt = (pend_r & ~enter & ~clr_ok) | hw_set;
	// the clear does not touch act
	assign act_nxt  = (act_r & ~leave) | enter;

	// state flops, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_r <= 1'b0;
			act_r  <= 1'b0;
			prev_r <= 1'b0;
		end else if (ce) begin
			pend_r <= pend_nxt;
			act_r  <= act_nxt;
			prev_r <= irq_in;
		end
	end

	assign pend = pend_r;
	assign act  = act_r;

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_quiet_leave;
		ce && is_pulse && leave && !enter && !rise && !set_pend;
	endsequence

	sequence s_pend_leave;
		ce && is_pulse && act && pend && leave && !enter && !clr_pend;
	endsequence

	property p_enter;
		@(posedge pclk) disable iff (!presetn)
		ce && enter && !leave && !set_pend && !(is_pulse && rise) |=> act && !pend;
	endproperty
	a_enter: assert property (p_enter) else $error("entry did not clear pend");

	property p_level_leave;
		@(posedge pclk) disable iff (!presetn)
		ce && !is_pulse && leave && !enter |=> !act && (pend == $past(irq_in));
	endproperty
	a_level_leave: assert property (p_level_leave) else $error("level return wrong");

	// a new pulse while the routine runs must keep act and set pend
	property p_repulse;
		@(posedge pclk) disable iff (!presetn)
		ce && is_pulse && act && rise && !leave && !clr_pend |=> pend && act;
	endproperty
	a_repulse: assert property (p_repulse) else $error("repulse not pending");

	property p_pulse_again;
		@(posedge pclk) disable iff (!presetn)
		s_pend_leave |=> pend && !act;
	endproperty
	a_pulse_again: assert property (p_pulse_again) else $error("repulse lost");

	property p_pulse_quiet;
		@(posedge pclk) disable iff (!presetn)
		s_quiet_leave and (!pend) |=> !pend && !act;
	endproperty
	a_pulse_quiet: assert property (p_pulse_quiet) else $error("pulse not inactive");

	property p_level_clear;
		@(posedge pclk) disable iff (!presetn)
		ce && !is_pulse && irq_in && clr_pend && !enter && !leave
			|=> pend == $past(pend) && act == $past(act);
	endproperty
	a_level_clear: assert property (p_level_clear) else $error("held level cleared");

	property p_pulse_clear;
		@(posedge pclk) disable iff (!presetn)
		ce && is_pulse && clr_pend && !set_pend && !rise && !enter && !leave
			|=> !pend && act == $past(act);
	endproperty
	a_pulse_clear: assert property (p_pulse_clear) else $error("pulse clear wrong");

endmodule : irq_line_state

//--- verilog/irq_select.sv
// picks the best enabled pending line by priority then number
// purely combinational; the caller registers the result
`timescale 1ns/10ps
module irq_select
	import irq_pkg::*;
#(
	parameter int N     = N_IRQ,
	parameter int W     = PRIO_W,
	parameter int IDX_W = $clog2(N_IRQ)
)(
	input  wire logic [N-1:0]   cand,
	input  wire logic [N*W-1:0] prio_flat,
	output logic                valid,
	output logic [IDX_W-1:0]    num,
	output logic [W-1:0]        prio
);
	// ************************************************************
	// linear scan
	// ************************************************************
	// strict less-than keeps the lower number on a tie; a tree
	// would be faster but 32 lines fit one cycle at 100 MHz
	always_comb begin
		valid = 1'b0;
		num   = '0;
		prio  = '1;
		for (int i = 0; i < N; i++) begin
			if (cand[i] && (!valid || prio_flat[i*W +: W] < prio)) begin
				valid = 1'b1;
				num   = IDX_W'(i);
				prio  = prio_flat[i*W +: W];
			end
		end
	end

endmodule : irq_select

//--- testbench/irq_core_model.sv
// core-side partner: takes the presented line, returns on command
// assumes the controller's clock and reset, commands from the bench
`timescale 1ns/10ps
module irq_core_model
	import irq_pkg::*;
#(
	parameter int IW = $clog2(N_IRQ)
)(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          take_en,
	input  wire logic [3:0]    take_lag,
	input  wire logic          leave_go,
	input  wire logic          irq_req,
	input  wire logic [IW-1:0] irq_num,
	output logic               svc_enter,
	output logic [IW-1:0]      svc_enter_num,
	output logic               svc_leave,
	output logic [IW-1:0]      svc_leave_num
);
	logic       busy_r;
	logic [3:0] wait_r;

	// one routine at a time, no nesting; a slow core waits take_lag cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_r        <= 1'b0;
			wait_r        <= 4'h0;
			svc_enter     <= 1'b0;
			svc_enter_num <= '0;
			svc_leave     <= 1'b0;
			svc_leave_num <= '0;
		end else begin
			svc_enter <= 1'b0;
			svc_leave <= 1'b0;
			if (leave_go && busy_r) begin
				svc_leave     <= 1'b1;
				svc_leave_num <= svc_enter_num;  // return from the line entered
				busy_r        <= 1'b0;
			end else if (take_en && irq_req && !busy_r) begin
				if (wait_r >= take_lag) begin
					svc_enter     <= 1'b1;
					svc_enter_num <= irq_num;
					busy_r        <= 1'b1;
					wait_r        <= 4'h0;
				end else begin
					wait_r <= wait_r + 4'h1;
				end
			end
		end
	end
endmodule : irq_core_model

//--- testbench/irq_priority_pending_ctrl_bench.sv
// self-checking bench: register table, then level, pulse and priority cases
// assumes apb answers within 20 cycles and the core model on the service strobes
`timescale 1ns/10ps
module irq_priority_pending_ctrl_bench;
	import irq_pkg::*;
	typedef struct packed {
		logic [11:0] wa;
		logic [31:0] wd;
		logic [11:0] ra;
		logic [31:0] exp;
		logic        err;
	} row_t;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata, irq_in = 32'h00000000;
	logic pready, pslverr, svc_enter, svc_leave, irq_req, take_en = 1'b0, leave_go = 1'b0;
	logic [4:0] svc_enter_num, svc_leave_num, irq_num;
	logic [1:0] irq_prio;
	logic [3:0] take_lag = 4'h0;
	logic [31:0] rdat;
	logic        rerr;
	int          n_fail = 0, checks = 0;
	row_t        rows[7];

	always #5 pclk = ~pclk;

	irq_priority_pending_ctrl irq_priority_pending_ctrl_inst (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
		.svc_enter(svc_enter), .svc_enter_num(svc_enter_num), .svc_leave(svc_leave),
		.svc_leave_num(svc_leave_num), .irq_req(irq_req), .irq_num(irq_num), .irq_prio(irq_prio));
	irq_core_model irq_core_model_inst (.pclk(pclk), .presetn(presetn), .take_en(take_en),
		.take_lag(take_lag), .leave_go(leave_go), .irq_req(irq_req), .irq_num(irq_num),
		.svc_enter(svc_enter), .svc_enter_num(svc_enter_num), .svc_leave(svc_leave),
		.svc_leave_num(svc_leave_num));

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask : chk

	// whole aligned words only; request held until pready seen high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			close_out();
		end
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000);
		chk(rdat, exp);
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc

	// bounded wait on the presented request
	task automatic wait_req();
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 30) begin
			cyc(1);
			n++;
		end
		if (n >= 30) begin
			n_fail++;
			close_out();
		end
	endtask : wait_req

	task automatic leave();
		@(posedge pclk);
		leave_go <= 1'b1;
		@(posedge pclk);
		leave_go <= 1'b0;
		cyc(4);
	endtask : leave

	// one-cycle pulse, the shortest a peripheral may give
	task automatic pulse(input int k);
		@(posedge pclk);
		irq_in[k] <= 1'b1;
		@(posedge pclk);
		irq_in[k] <= 1'b0;
		cyc(3);
	endtask : pulse

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rows[0] = '{12'h400, 32'hFFFFFFFF, 12'h400, 32'hC0C0C0C0, 1'b0};
		rows[1] = '{12'h41C, 32'h7F3FBF01, 12'h41C, 32'h40008000, 1'b0};
		rows[2] = '{12'h380, 32'h000000F0, 12'h380, 32'h000000F0, 1'b0};
		rows[3] = '{12'h100, 32'h0000000F, 12'h100, 32'h0000000F, 1'b0};
		rows[4] = '{12'h180, 32'h00000001, 12'h100, 32'h0000000E, 1'b0};
		rows[5] = '{12'h300, 32'hFFFFFFFF, 12'h300, 32'h00000000, 1'b0};
		rows[6] = '{12'h010, 32'hFFFFFFFF, 12'h010, 32'h00000000, 1'b1};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		cyc(1);
		chk({31'h0, irq_req}, 32'h0);
		for (int i = 0; i < 12; i++)
			rd((i < 4) ? 12'h100 + 12'(i * 128) : 12'h400 + 12'((i - 4) * 4), 32'h0);
		// table of register writes and the words they read back as
		for (int i = 0; i < 7; i++) begin
			wr(rows[i].wa, rows[i].wd);
			chk({31'h0, rerr}, {31'h0, rows[i].err});
			rd(rows[i].ra, rows[i].exp);
		end
		// level line 1: pending while disabled, never presented until enabled
		wr(12'h180, 32'hFFFFFFFF);
		@(posedge pclk);
		irq_in[1] <= 1'b1;
		cyc(4);
		rd(12'h200, 32'h00000002);
		chk({31'h0, irq_req}, 32'h0);
		take_lag <= 4'h3;
		take_en  <= 1'b1;
		wr(12'h100, 32'h00000002);
		wait_req();
		chk({27'h0, irq_num}, 32'h1);
		cyc(8);
		take_en <= 1'b0;
		rd(12'h300, 32'h00000002);
		rd(12'h200, 32'h00000000);
		leave();
		rd(12'h200, 32'h00000002);
		rd(12'h300, 32'h00000000);
		wr(12'h280, 32'h00000002);
		rd(12'h200, 32'h00000002);
		@(posedge pclk);
		irq_in[1] <= 1'b0;
		wr(12'h280, 32'h00000002);
		rd(12'h200, 32'h00000000);
		// pulse line 5: repeat pulses during service, clears, returns
		take_lag <= 4'h0;
		take_en  <= 1'b1;
		wr(12'h100, 32'h00000020);
		pulse(5);
		cyc(4);
		take_en <= 1'b0;
		rd(12'h300, 32'h00000020);
		pulse(5);
		rd(12'h200, 32'h00000020);
		rd(12'h300, 32'h00000020);
		wr(12'h280, 32'h00000020);
		rd(12'h200, 32'h00000000);
		rd(12'h300, 32'h00000020);
		pulse(5);
		leave();
		rd(12'h200, 32'h00000020);
		rd(12'h300, 32'h00000000);
		take_en <= 1'b1;
		cyc(8);
		take_en <= 1'b0;
		leave();
		rd(12'h200, 32'h00000000);
		rd(12'h300, 32'h00000000);
		wr(12'h180, 32'hFFFFFFFF);
		wr(12'h200, 32'h00000020);
		wr(12'h280, 32'h00000020);
		rd(12'h200, 32'h00000000);
		// priority: tie between 9 and 12 first, then 12 raised to level 0
		wr(12'h400, 32'h00800000);
		wr(12'h408, 32'h00004000);
		wr(12'h40C, 32'h00000040);
		wr(12'h200, 32'h00001204);
		wr(12'h100, 32'hFFFFFFFF);
		wait_req();
		cyc(2);
		chk({27'h0, irq_num}, 32'h9);
		chk({30'h0, irq_prio}, 32'h1);
		wr(12'h40C, 32'h00000000);
		cyc(3);
		chk({27'h0, irq_num}, 32'hC);
		chk({30'h0, irq_prio}, 32'h0);
		wr(12'h280, 32'hFFFFFFFF);
		cyc(3);
		chk({31'h0, irq_req}, 32'h0);
		// disabled line 0 still pends, is shown once enabled; ce freezes sampling
		wr(12'h180, 32'h00000001);
		wr(12'h200, 32'h00000001);
		cyc(3);
		chk({31'h0, irq_req}, 32'h0);
		rd(12'h200, 32'h00000001);
		wr(12'h100, 32'h00000001);
		cyc(3);
		chk({26'h0, irq_req, irq_num}, 32'h20);
		@(posedge pclk);
		ce <= 1'b0;
		pulse(4);
		@(posedge pclk);
		ce <= 1'b1;
		cyc(2);
		rd(12'h200, 32'h00000001);
		close_out();
	end
endmodule : irq_priority_pending_ctrl_bench
